// File: hdl/scc_clock_ctrl.sv
// System clock, PLL and clock output control with watchdog service decode.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module scc_clock_ctrl
  import scc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic supervisor,
  output logic [15:0] reg_rdata,
  // Straps and system status.
  input wire logic [1:0] clock_mode_pins,
  input wire logic [2:0] cpu_irq_level,
  input wire logic cp_busy,
  input wire logic low_power_stop,
  // Watchdog and periodic timer hooks.
  input wire logic watchdog_enable_bit,
  input wire logic watchdog_expire,
  input wire logic periodic_prescale_bit,
  output logic watchdog_restart,
  output logic watchdog_timeout,
  output logic periodic_tick,
  // PLL status.
  output logic strap_done,
  output logic pll_power,
  output logic pll_locked,
  output logic input_prescale_enable,
  output logic [12:0] pll_factor,
  // Derived clock enables.
  output logic integration_clock_en,
  output logic sync_clock_en,
  output logic baud_generator_clock_en,
  // Clock output pins.
  output logic first_clock_output,
  output logic [1:0] first_output_mode,
  output logic second_clock_output,
  output logic [1:0] second_output_mode
);
  logic [1:0] pins_s1_q, pins_s2_q, pins_s3_q;
  logic [1:0] boot_cnt_q;
  logic strap_load;
  logic clkout_wp_q;
  logic [1:0] mode1_q, mode2_q, mode1_app_q, mode2_app_q;
  logic pll_en_q, pll_wp_q, prescale_q, stop_src_q;
  logic [11:0] mf_q;
  logic [15:0] cdv_q;
  logic wr_ok, clk_wr, pll_wr, cdv_wr, wdog_wr;
  logic [7:0] lock_cnt_q;
  logic [8:0] relock_age_q;
  logic pll_run, xtal_mode, irq_wake, cp_wake, use_low;
  logic [3:0] sys_shift;
  logic [8:0] pre_cnt_q;
  scc_wdog_t wd_state_q;
  logic out1_q, out2_q, restart_q, timeout_q;
  logic [15:0] rdata_q;

  // Mode pins pass three flops; the value is caught once stages two and three agree.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_s1_q <= 2'h0;
      pins_s2_q <= 2'h0;
      pins_s3_q <= 2'h0;
    end else begin
      pins_s1_q <= clock_mode_pins;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_cnt_q <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      if (boot_cnt_q != BOOT_CYCLES) begin
        boot_cnt_q <= boot_cnt_q + 2'h1;
      end
      if (strap_load) begin
        strap_done <= 1'b1;
      end
    end
  end

  assign strap_load = !strap_done && boot_cnt_q == BOOT_CYCLES && pins_s2_q == pins_s3_q;

  // Registers are not written until the straps have been taken.
  assign wr_ok = reg_wr & strap_done;
  assign clk_wr = wr_ok & supervisor & reg_addr == ADDR_CLKOUT & !clkout_wp_q;
  assign pll_wr = wr_ok & supervisor & reg_addr == ADDR_PLL & !pll_wp_q;
  assign cdv_wr = wr_ok & supervisor & reg_addr == ADDR_CDV & !cdv_q[CDV_WP];
  assign wdog_wr = wr_ok & reg_addr == ADDR_WDOG;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkout_wp_q <= 1'b0;
      mode1_q <= MODE_FULL;
      mode2_q <= MODE_OFF;
    end else if (strap_load) begin
      mode1_q <= (pins_s3_q == PINS_ALT_OUT) ? MODE_OFF : MODE_FULL;
      mode2_q <= (pins_s3_q == PINS_ALT_OUT) ? MODE_FULL : MODE_OFF;
    end else if (clk_wr) begin
      clkout_wp_q <= reg_wdata[CLKO_WP];
      mode1_q <= reg_wdata[CLKO_M1 +: 2];
      mode2_q <= reg_wdata[CLKO_M2 +: 2];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_en_q <= 1'b1;
      pll_wp_q <= 1'b0;
      prescale_q <= 1'b0;
      stop_src_q <= 1'b0;
      mf_q <= MF_RST_LOW;
    end else if (strap_load) begin
      pll_en_q <= (pins_s3_q != PINS_NO_PLL);
      prescale_q <= (pins_s3_q == PINS_PRESCALE);
      mf_q <= pins_s3_q[1] ? MF_RST_HIGH : MF_RST_LOW;
    end else if (pll_wr) begin
      pll_en_q <= reg_wdata[PLL_EN];
      pll_wp_q <= reg_wdata[PLL_WP];
      prescale_q <= reg_wdata[PLL_PRE];
      stop_src_q <= reg_wdata[PLL_STOPSRC];
      mf_q <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cdv_q <= CDV_RST;
    end else if (cdv_wr) begin
      cdv_q <= reg_wdata;
    end
  end

  // The PLL is powered down in stop when the crystal feeds the system.
  assign xtal_mode = low_power_stop & !stop_src_q;
  assign pll_run = pll_en_q & !xtal_mode;
  assign pll_power = pll_run;
  assign input_prescale_enable = prescale_q;
  assign pll_factor = {1'b0, mf_q} + 13'h0001;

  // Any accepted multiplier write restarts acquisition; derived clocks wait for lock.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_cnt_q <= 8'h00;
      pll_locked <= 1'b0;
    end else if (!pll_run || pll_wr || !strap_done) begin
      lock_cnt_q <= 8'h00;
      pll_locked <= 1'b0;
    end else if (!pll_locked) begin
      if (lock_cnt_q == PLL_LOCK_LAST) begin
        pll_locked <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 8'h01;
      end
    end
  end

  // Cycles since the last accepted PLL write, stopping at the idle value; idle while the PLL is not running.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      relock_age_q <= RELOCK_AGE_IDLE;
    end else if (pll_wr) begin
      relock_age_q <= 9'h000;
    end else if (!pll_run) begin
      relock_age_q <= RELOCK_AGE_IDLE;
    end else if (relock_age_q != RELOCK_AGE_IDLE) begin
      relock_age_q <= relock_age_q + 9'h001;
    end
  end

  assign irq_wake = cdv_q[CDV_THR +: 3] != THR_OFF && cpu_irq_level > cdv_q[CDV_THR +: 3];
  assign cp_wake = cdv_q[CDV_CPREQ] & cp_busy;
  assign use_low = cdv_q[CDV_SRC] & !irq_wake & !cp_wake;

  always_comb begin
    if (xtal_mode) begin
      sys_shift = prescale_q ? XTAL_SHIFT_DIV256 : XTAL_SHIFT_DIV2;
    end else if (use_low) begin
      sys_shift = scc_low_shift(cdv_q[CDV_LOW +: 3]);
    end else begin
      sys_shift = scc_high_shift(cdv_q[CDV_HIGH +: 3]);
    end
  end

  scc_clk_div u_sys_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(pll_locked | xtal_mode),
    .shift(sys_shift),
    .tick(integration_clock_en)
  );

  // Sync and baud dividers only follow the lock state; their codes never touch it.
  scc_clk_div u_sync_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(pll_locked),
    .shift(scc_quad_shift(cdv_q[CDV_SYNC +: 2])),
    .tick(sync_clock_en)
  );

  scc_clk_div u_baud_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(pll_locked),
    .shift(scc_quad_shift(cdv_q[CDV_BAUD +: 2])),
    .tick(baud_generator_clock_en)
  );

  // Mode changes are applied only while the pin is low or held, so no runt appears.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode1_app_q <= MODE_FULL;
      mode2_app_q <= MODE_OFF;
    end else begin
      if (!out1_q || mode1_app_q == MODE_OFF) begin
        mode1_app_q <= mode1_q;
      end
      if (!out2_q || mode2_app_q == MODE_OFF) begin
        mode2_app_q <= mode2_q;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out1_q <= 1'b0;
      out2_q <= 1'b1;
    end else begin
      if (mode1_app_q == MODE_OFF) begin
        out1_q <= 1'b1;
      end else if (!pll_locked) begin
        out1_q <= 1'b0;
      end else begin
        out1_q <= !out1_q;
      end
      if (mode2_app_q == MODE_OFF) begin
        out2_q <= 1'b1;
      end else if (!pll_locked && !xtal_mode) begin
        out2_q <= 1'b0;
      end else if (integration_clock_en) begin
        out2_q <= !out2_q;
      end
    end
  end

  assign first_clock_output = out1_q;
  assign second_clock_output = out2_q;
  assign first_output_mode = mode1_app_q;
  assign second_output_mode = mode2_app_q;

  // Only a 55h write whose next service-location write is AAh restarts the watchdog.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_state_q <= WD_IDLE;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (wdog_wr) begin
        unique case (wd_state_q)
          WD_IDLE: begin
            wd_state_q <= (reg_wdata[7:0] == WDOG_KEY1) ? WD_ARMED : WD_IDLE;
          end
          WD_ARMED: begin
            restart_q <= (reg_wdata[7:0] == WDOG_KEY2);
            wd_state_q <= (reg_wdata[7:0] == WDOG_KEY1) ? WD_ARMED : WD_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= watchdog_expire & watchdog_enable_bit;
    end
  end

  assign watchdog_restart = restart_q;
  assign watchdog_timeout = timeout_q;

  // The 512 prescaler runs free and is not realigned when the timer starts.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_q <= 9'h000;
    end else begin
      pre_cnt_q <= pre_cnt_q + 9'h001;
    end
  end

  assign periodic_tick = !periodic_prescale_bit || pre_cnt_q == PERIODIC_LAST;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= 16'h0000;
      if (reg_rd && supervisor) begin
        unique case (reg_addr)
          ADDR_CLKOUT: rdata_q <= {8'h00, clkout_wp_q, 3'h0, mode2_q, mode1_q};
          ADDR_PLL: rdata_q <= {pll_en_q, pll_wp_q, prescale_q, stop_src_q, mf_q};
          ADDR_CDV: rdata_q <= cdv_q;
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;

  a_wdog_pair: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wd_state_q == WD_ARMED && wdog_wr && reg_wdata[7:0] == WDOG_KEY2) |=> watchdog_restart)
    else $error("watchdog key pair did not restart");
  a_wdog_lone: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wd_state_q == WD_IDLE && wdog_wr) |=> !watchdog_restart)
    else $error("watchdog restarted without first key");
  a_wdog_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == ADDR_WDOG) |=> reg_rdata == 16'h0000)
    else $error("service location read not zero");
  a_wdog_disabled: assert property (@(posedge core_clk) disable iff (sys_rst)
    !watchdog_enable_bit |=> !watchdog_timeout)
    else $error("timeout while watchdog disabled");
  a_protect_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pll_wp_q && reg_wr && reg_addr == ADDR_PLL) |=> $stable(mf_q) && pll_wp_q)
    else $error("protected PLL register changed");
  a_user_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!supervisor && reg_wr && reg_addr == ADDR_CDV) |=> $stable(cdv_q))
    else $error("user write changed divider register");
  a_held_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode1_app_q == MODE_OFF) [*2] |-> first_clock_output)
    else $error("first output not held high");
  a_no_runt: assert property (@(posedge core_clk) disable iff (sys_rst)
    $changed(mode1_app_q) |-> !$past(out1_q) || $past(mode1_app_q) == MODE_OFF)
    else $error("output mode changed mid pulse");
  a_strap_modes: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strap_load && pins_s3_q == PINS_ALT_OUT) |=> mode1_q == MODE_OFF && mode2_q == MODE_FULL)
    else $error("output modes wrong after strap");
  a_relock_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
    pll_wr |=> (!pll_locked && !sync_clock_en) [*8])
    else $error("clocks ran during reacquisition");
  a_lock_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
    relock_age_q == 9'(PLL_LOCK_CYC) |-> pll_locked)
    else $error("PLL did not relock in time");
  a_irq_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!xtal_mode && cdv_q[CDV_THR +: 3] != THR_OFF && cpu_irq_level > cdv_q[CDV_THR +: 3])
    |-> sys_shift == scc_high_shift(cdv_q[CDV_HIGH +: 3]))
    else $error("interrupt did not restore high rate");

  c_restart: cover property (@(posedge core_clk) disable iff (sys_rst) watchdog_restart);
  c_relock: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(pll_locked));
  c_low_rate: cover property (@(posedge core_clk) disable iff (sys_rst)
    use_low && integration_clock_en);
endmodule

// File: common/scc_pkg.sv
// Constants and decode helpers for the system clock and PLL control block.
// Notes on behaviour
// - Watchdog is restarted only by writing 55h then AAh to the service location.
// - The service location takes writes in either mode once the straps are taken, and always reads as zero.
// - A cleared watchdog enable bit stops the watchdog from timing out.
// - With the 512 prescaler, the first periodic tick may come up to 512 clocks early.
// - Each control register has a write-protect bit; once set, later writes are dropped.
// - The three control registers answer only supervisor accesses.
// - Output mode: 00 full, 01 two-thirds, 10 one-third strength, 11 held high.
// - Output mode changes never cut a clock pulse short on the pin.
// - Second output mode resets to 11, or to 00 when the mode pins read 01.
// - First output mode resets to 00, or to 11 when the mode pins read 01.
// - First output: high at 11, else low while unlocked, else oscillator rate.
// - PLL control writes are dropped while its write-protect bit is one.
// - PLL enable resets to one unless pins read 00; multiplier resets to 0 or 400.
// - Prescale bit selects divide-by-128 ahead of the PLL; set by pins at reset.
// - In stop with source bit 0, run from crystal /2 or /256, PLL off.
// - System factor equals multiplier field plus one, from 1 to 4096.
// - Each multiplier write drops lock and gates PLL clocks until relock.
// - Divider writes are dropped while protected; the register resets to zero.
// - Sync divider codes 00 to 11 divide by 1, 4, 16, 64 without unlocking.
// - Baud divider codes 00 to 11 divide by 1, 4, 16, 64 without unlocking.
// - Interrupt above the threshold returns the clock to high rate; 111 disables this.
// - Clock source bit set selects the low divider, clear the high divider.
// - High divider codes 000 to 110 divide by 1 to 64; 111 reserved.
// - Low divider codes 000 to 101 divide by 2 to 64, 111 by 256.
// - With request bit set, a busy comms processor returns the clock to high rate.
package scc_pkg;
  localparam logic [3:0] ADDR_CLKOUT = 4'h0;
  localparam logic [3:0] ADDR_PLL = 4'h1;
  localparam logic [3:0] ADDR_CDV = 4'h2;
  localparam logic [3:0] ADDR_WDOG = 4'h3;
  localparam logic [7:0] WDOG_KEY1 = 8'h55;
  localparam logic [7:0] WDOG_KEY2 = 8'haa;
  // Clock output control fields.
  localparam int CLKO_WP = 7;
  localparam int CLKO_M2 = 2;
  localparam int CLKO_M1 = 0;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [1:0] MODE_FULL = 2'h0;
  // PLL control fields.
  localparam int PLL_EN = 15;
  localparam int PLL_WP = 14;
  localparam int PLL_PRE = 13;
  localparam int PLL_STOPSRC = 12;
  localparam logic [11:0] MF_RST_LOW = 12'h000;
  localparam logic [11:0] MF_RST_HIGH = 12'h190;
  // Clock divider control fields.
  localparam int CDV_WP = 15;
  localparam int CDV_SYNC = 13;
  localparam int CDV_BAUD = 11;
  localparam int CDV_THR = 8;
  localparam int CDV_CPREQ = 7;
  localparam int CDV_LOW = 4;
  localparam int CDV_HIGH = 1;
  localparam int CDV_SRC = 0;
  localparam logic [15:0] CDV_RST = 16'h0000;
  localparam logic [2:0] THR_OFF = 3'h7;
  // Clock mode pin values with a special meaning.
  localparam logic [1:0] PINS_NO_PLL = 2'h0;
  localparam logic [1:0] PINS_ALT_OUT = 2'h1;
  localparam logic [1:0] PINS_PRESCALE = 2'h3;
  // Reset values and cycle counts.
  localparam logic [3:0] DIV_SHIFT_RST = 4'h0;
  localparam logic [3:0] XTAL_SHIFT_DIV2 = 4'h1;
  localparam logic [3:0] XTAL_SHIFT_DIV256 = 4'h8;
  localparam logic [1:0] BOOT_CYCLES = 2'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_LOCK_NS = 2000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] PLL_LOCK_LAST = 8'(PLL_LOCK_CYC - 1);
  localparam logic [8:0] PERIODIC_LAST = 9'h1ff;
  localparam logic [8:0] RELOCK_AGE_IDLE = 9'h1ff;

  typedef enum logic {WD_IDLE = 1'b0, WD_ARMED = 1'b1} scc_wdog_t;

  // High divider: code n divides by 2**n; the reserved code stays at 64.
  function automatic logic [3:0] scc_high_shift(input logic [2:0] code);
    scc_high_shift = (code == 3'h7) ? 4'h6 : {1'b0, code};
  endfunction

  // Low divider: code n divides by 2**(n+1); 111 and reserved 110 give 256.
  function automatic logic [3:0] scc_low_shift(input logic [2:0] code);
    scc_low_shift = (code >= 3'h6) ? 4'h8 : {1'b0, code} + 4'h1;
  endfunction

  // Sync and baud dividers: code n divides by 4**n.
  function automatic logic [3:0] scc_quad_shift(input logic [1:0] code);
    scc_quad_shift = {1'b0, code, 1'b0};
  endfunction
endpackage

// File: hdl/scc_clk_div.sv
// Power-of-two clock enable divider with boundary-aligned ratio changes.
`timescale 1ns/10ps
module scc_clk_div
  import scc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control.
  input wire logic run,
  input wire logic [3:0] shift,
  // Enable pulse, one cycle per divided period.
  output logic tick
);
  logic [7:0] cnt_q;
  logic [3:0] shift_q;
  logic [7:0] last;
  logic at_end;

  assign last = 8'((9'h001 << shift_q) - 9'h001);
  assign at_end = (cnt_q == last);
  assign tick = run & at_end;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else if (!run || at_end) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // A new ratio is picked up only when a period ends or while stopped, so no pulse is shortened.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= DIV_SHIFT_RST;
    end else if (!run || at_end) begin
      shift_q <= shift;
    end
  end
endmodule

// File: dv/tb.sv
// Self-checking testbench for the system clock and PLL control block.
`timescale 1ns/10ps
module tb;
  import scc_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic supervisor = 1'b1;
  logic [15:0] reg_rdata;
  logic [1:0] clock_mode_pins = 2'h3;
  logic [2:0] cpu_irq_level = 3'h0;
  logic cp_busy = 1'b0;
  logic low_power_stop = 1'b0;
  logic watchdog_enable_bit = 1'b0;
  logic watchdog_expire = 1'b0;
  logic periodic_prescale_bit = 1'b0;
  logic watchdog_restart, watchdog_timeout, periodic_tick, strap_done, pll_power, pll_locked;
  logic input_prescale_enable, integration_clock_en, sync_clock_en, baud_generator_clock_en;
  logic first_clock_output, second_clock_output;
  logic [12:0] pll_factor;
  logic [1:0] first_output_mode, second_output_mode;
  int failures = 0;
  int checks = 0;
  int restarts = 0;
  int ci, cs, cb, cq;
  logic [15:0] pv [3] = '{16'h008c, 16'hc190, 16'h8000};

  scc_clock_ctrl dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .supervisor(supervisor), .reg_rdata(reg_rdata),
    .clock_mode_pins(clock_mode_pins), .cpu_irq_level(cpu_irq_level), .cp_busy(cp_busy),
    .low_power_stop(low_power_stop), .watchdog_enable_bit(watchdog_enable_bit),
    .watchdog_expire(watchdog_expire), .periodic_prescale_bit(periodic_prescale_bit),
    .watchdog_restart(watchdog_restart), .watchdog_timeout(watchdog_timeout),
    .periodic_tick(periodic_tick), .strap_done(strap_done), .pll_power(pll_power),
    .pll_locked(pll_locked), .input_prescale_enable(input_prescale_enable),
    .pll_factor(pll_factor), .integration_clock_en(integration_clock_en),
    .sync_clock_en(sync_clock_en), .baud_generator_clock_en(baud_generator_clock_en),
    .first_clock_output(first_clock_output), .first_output_mode(first_output_mode),
    .second_clock_output(second_clock_output), .second_output_mode(second_output_mode)
  );

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (watchdog_restart === 1'b1) begin
      restarts <= restarts + 1;
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic wait_lock();
    int i;
    for (i = 0; i < 400 && pll_locked !== 1'b1; i++) @(posedge core_clk);
    if (pll_locked !== 1'b1) begin
      failures++;
      $display("[FAIL] lock wait expected 1 seen 0");
      conclude();
    end
  endtask

  task automatic boot(input logic [1:0] p);
    int i;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    clock_mode_pins <= p;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 20 && strap_done !== 1'b1; i++) @(posedge core_clk);
    chk("strap done", 16'h1, {15'h0, strap_done});
    repeat (2) @(posedge core_clk);
  endtask

  // Counts enable pulses at falling edges, where the combinational enables are settled.
  task automatic cnt(input int n);
    ci = 0;
    cs = 0;
    cb = 0;
    cq = 0;
    repeat (n) begin
      @(negedge core_clk);
      ci += (integration_clock_en === 1'b1);
      cs += (sync_clock_en === 1'b1);
      cb += (baud_generator_clock_en === 1'b1);
      cq += (periodic_tick === 1'b1);
    end
  endtask

  task automatic div(input logic [15:0] v, input logic [2:0] lv, input logic bz, input int ei,
                     input int es);
    @(posedge core_clk);
    cpu_irq_level <= lv;
    cp_busy <= bz;
    wr(ADDR_CDV, v);
    repeat (300) @(posedge core_clk);
    cnt(256);
    chk("system rate", 16'(ei), 16'(ci));
    chk("sync rate", 16'(es), 16'(cs));
    chk("baud rate", 16'(es), 16'(cb));
    chk("lock kept", 16'h1, {15'h0, pll_locked});
  endtask

  initial begin
    int p, k, n;
    logic b;
    for (p = 0; p < 4; p++) begin
      boot(2'(p));
      rd_chk("clkout reset", ADDR_CLKOUT, (p == 1) ? 16'h0003 : 16'h000c);
      rd_chk("pll reset", ADDR_PLL, {p != 0, 1'b0, p == 3, 1'b0,
             p[1] ? MF_RST_HIGH : MF_RST_LOW});
      rd_chk("divider reset", ADDR_CDV, CDV_RST);
      chk("first pin reset", {15'h0, p == 1}, {15'h0, first_clock_output});
      if (p != 0) begin
        wait_lock();
        chk("factor reset", p[1] ? 16'h0191 : 16'h0001, {3'h0, pll_factor});
      end
    end
    $display("reset test done");
    @(posedge core_clk);
    supervisor <= 1'b0;
    wr(ADDR_CDV, 16'h0001);
    rd_chk("user read", ADDR_PLL, 16'h0000);
    wr(ADDR_WDOG, {8'h0, WDOG_KEY1});
    wr(ADDR_WDOG, {8'h0, WDOG_KEY2});
    rd_chk("service read", ADDR_WDOG, 16'h0000);
    @(posedge core_clk);
    supervisor <= 1'b1;
    rd_chk("divider kept", ADDR_CDV, 16'h0000);
    chk("restart", 16'h1, 16'(restarts));
    wr(ADDR_WDOG, 16'h0055);
    wr(ADDR_WDOG, 16'h0012);
    wr(ADDR_WDOG, 16'h00aa);
    wr(ADDR_WDOG, 16'h00aa);
    wr(ADDR_WDOG, 16'h0055);
    wr(ADDR_CDV, 16'h0000);
    wr(ADDR_WDOG, 16'h00aa);
    repeat (2) @(posedge core_clk);
    chk("restart count", 16'h2, 16'(restarts));
    watchdog_expire <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("timeout off", 16'h0, {15'h0, watchdog_timeout});
    watchdog_enable_bit <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("timeout on", 16'h1, {15'h0, watchdog_timeout});
    watchdog_expire <= 1'b0;
    $display("watchdog test done");
    wr(ADDR_WDOG, 16'h0055);
    wr(ADDR_WDOG, 16'h00aa);
    wr(ADDR_PLL, 16'h8fff);
    #1;
    chk("lock dropped", 16'h0, {15'h0, pll_locked});
    cnt(50);
    chk("gated clocks", 16'h0, 16'(ci + cs + cb));
    chk("first pin unlocked", 16'h0, {15'h0, first_clock_output});
    wr(ADDR_WDOG, 16'h0055);
    wr(ADDR_WDOG, 16'h00aa);
    wait_lock();
    chk("factor max", 16'h1000, {3'h0, pll_factor});
    chk("prescale off", 16'h0, {15'h0, input_prescale_enable});
    @(negedge core_clk);
    b = first_clock_output;
    @(negedge core_clk);
    chk("first pin toggles", {15'h0, ~b}, {15'h0, first_clock_output});
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CLKOUT, {12'h0, 2'(k), 2'(3 - k)});
      repeat (20) @(posedge core_clk);
      #1;
      chk("first mode", 16'(3 - k), {14'h0, first_output_mode});
      chk("second mode", 16'(k), {14'h0, second_output_mode});
      if (k == 0) chk("first pin high", 16'h1, {15'h0, first_clock_output});
      if (k == 3) chk("second pin high", 16'h1, {15'h0, second_clock_output});
    end
    $display("pll and output test done");
    @(posedge core_clk);
    low_power_stop <= 1'b1;
    repeat (300) @(posedge core_clk);
    #1;
    chk("pll off in stop", 16'h0, {15'h0, pll_power});
    cnt(256);
    chk("crystal rate", 16'h0080, 16'(ci));
    wr(ADDR_PLL, 16'h9fff);
    #1;
    chk("pll on in stop", 16'h1, {15'h0, pll_power});
    @(posedge core_clk);
    low_power_stop <= 1'b0;
    wait_lock();
    periodic_prescale_bit <= 1'b1;
    cnt(1024);
    chk("periodic slow", 16'h2, 16'(cq));
    @(posedge core_clk);
    periodic_prescale_bit <= 1'b0;
    cnt(16);
    chk("periodic fast", 16'h0010, 16'(cq));
    $display("stop and periodic test done");
    for (k = 0; k < 8; k++) begin
      n = k % 4;
      div({1'b0, 2'(n), 2'(n), 7'h0, 3'(k), 1'b0}, 3'h0, 1'b0, 256 >> ((k == 7) ? 6 : k),
          256 >> (2 * n));
    end
    for (k = 0; k < 8; k++) begin
      div({9'h0, 3'(k), 4'h1}, 3'h0, 1'b0, (k >= 6) ? 1 : 256 >> (k + 1), 256);
    end
    div(16'h0271, 3'h3, 1'b0, 256, 256);
    div(16'h0271, 3'h2, 1'b0, 1, 256);
    div(16'h0771, 3'h7, 1'b0, 1, 256);
    div(16'h07f1, 3'h0, 1'b1, 256, 256);
    div(16'h0771, 3'h0, 1'b1, 1, 256);
    $display("divider test done");
    for (k = 0; k < 3; k++) begin
      wr(4'(k), pv[k]);
      rd_chk("protect set", 4'(k), pv[k]);
      wr(4'(k), ~pv[k] & 16'h7fff);
      rd_chk("protect hold", 4'(k), pv[k]);
    end
    $display("protect test done");
    conclude();
  end
endmodule
